// file: hdl/lfsrs_cfg.svh
// Constants for the panel frame-start row select block
`ifndef LFSRS_CFG_SVH
`define LFSRS_CFG_SVH
// Indices on the indexed register port
`define LFSRS_IDX_ROW_ONE 8'h02
`define LFSRS_IDX_ROW_TWO 8'h03
`define LFSRS_IDX_ROW_THREE 8'h04
`define LFSRS_IDX_ROW_FOUR 8'h05
`define LFSRS_IDX_OVERFLOW 8'h06
`define LFSRS_IDX_SIGNAL_CTL 8'h07
`define LFSRS_IDX_SIZE_CTL 8'h09
`define LFSRS_IDX_EXP_ROW 8'h0c
`define LFSRS_IDX_EXP_OVF 8'h0e
`define LFSRS_IDX_EXPAND_CENTER 8'h2d
`define LFSRS_IDX_SECOND_EXPAND 8'h2e
// Storage slots inside the register file
`define LFSRS_NUM_SLOTS 11
`define LFSRS_SLOT_ROW_ONE 4'h0
`define LFSRS_SLOT_ROW_TWO 4'h1
`define LFSRS_SLOT_ROW_THREE 4'h2
`define LFSRS_SLOT_ROW_FOUR 4'h3
`define LFSRS_SLOT_OVERFLOW 4'h4
`define LFSRS_SLOT_SIGNAL_CTL 4'h5
`define LFSRS_SLOT_SIZE_CTL 4'h6
`define LFSRS_SLOT_EXP_ROW 4'h7
`define LFSRS_SLOT_EXP_OVF 4'h8
`define LFSRS_SLOT_EXPAND_CENTER 4'h9
`define LFSRS_SLOT_SECOND_EXPAND 4'ha
// Reset value of every register
`define LFSRS_REG_RST 8'h00
// Field positions
`define LFSRS_UNLOCK_BIT 7
`define LFSRS_EXPAND_BIT 1
`define LFSRS_CENTER_BIT 0
`define LFSRS_GFX_EXP_BIT 1
`define LFSRS_TXT_EXP_BIT 0
`define LFSRS_TWO_LINE_BIT 3
`define LFSRS_SIZE_LSB 2
`define LFSRS_OVF_ONE_LSB 6
`define LFSRS_OVF_TWO_LSB 4
`define LFSRS_OVF_THREE_LSB 2
`define LFSRS_OVF_FOUR_LSB 0
`define LFSRS_EXP_OVF_LSB 0
// Field encodings
`define LFSRS_SIZE_800 2'h1
`define LFSRS_RES_480 2'h3
`define LFSRS_RES_350 2'h2
`define LFSRS_RES_400 2'h1
`define LFSRS_RES_600 2'h0
`endif

// file: hdl/lfsrs_pkg.sv
// Types shared by the panel frame-start row select block
`default_nettype none
package lfsrs_pkg;
  // One access on the indexed register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } lfsrs_io_req_t;
  // Display timing marks, one-cycle pulses
  typedef struct packed {
    logic frame_start;
    logic line_start;
  } lfsrs_timing_t;
  // Register contents needed by the row selector
  typedef struct packed {
    logic [7:0] row_one;
    logic [7:0] row_two;
    logic [7:0] row_three;
    logic [7:0] row_four;
    logic [7:0] overflow;
    logic [7:0] exp_row;
    logic [7:0] exp_ovf;
    logic [7:0] expand_center;
    logic [7:0] second_expand;
    logic [7:0] size_ctl;
  } lfsrs_regs_t;
  typedef logic [9:0] lfsrs_row_t;
  // Pulse shaper states, Gray along idle, first line, second line
  typedef enum logic [1:0] {
    LFSRS_IDLE = 2'b00,
    LFSRS_LINE_A = 2'b01,
    LFSRS_LINE_B = 2'b11
  } lfsrs_state_t;
endpackage
`default_nettype wire

// file: hdl/lfsrs_regfile.sv
// Byte register file with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "lfsrs_cfg.svh"
module lfsrs_regfile (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic wr_en_in,
  input wire logic [3:0] wr_slot_in,
  input wire logic [7:0] wdata_in,
  input wire logic rd_en_in,
  input wire logic rd_hit_in,
  input wire logic [3:0] rd_slot_in,
  output logic [7:0] rdata_out,
  output logic [`LFSRS_NUM_SLOTS*8-1:0] all_regs_out
);
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;
  logic [7:0] store [`LFSRS_NUM_SLOTS];

  // One byte per slot, cleared at reset
  genvar g;
  for (g = 0; g < `LFSRS_NUM_SLOTS; g++) begin : g_slot
    logic [7:0] nxt_byte;
    logic [7:0] byte_ff;
    always_comb begin
      nxt_byte = byte_ff;
      if (wr_en_in && wr_slot_in == 4'(g)) begin
        nxt_byte = wdata_in;
      end
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        byte_ff <= `LFSRS_REG_RST;
      end else begin
        byte_ff <= nxt_byte;
      end
    end
    assign store[g] = byte_ff;
    assign all_regs_out[g*8 +: 8] = byte_ff;
  end

  // Read data held until the next read; misses answer zero
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_en_in) begin
      nxt_rdata = rd_hit_in ? store[rd_slot_in] : 8'h00;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_out = rdata_ff;
endmodule
`default_nettype wire

// file: hdl/lfsrs_row_select.sv
// Picks the active 10-bit frame-start row from panel mode and resolution
`timescale 1ns/1ns
`default_nettype none
`include "lfsrs_cfg.svh"
module lfsrs_row_select (
  input wire lfsrs_pkg::lfsrs_regs_t regs_in,
  input wire logic [1:0] misc_res_in,
  input wire logic graphics_mode_in,
  output lfsrs_pkg::lfsrs_row_t pos_out,
  output logic valid_out
);
  import lfsrs_pkg::*;
  logic is_800;
  logic exp_640;
  logic exp_800;
  logic center;
  lfsrs_row_t row_one_full;
  lfsrs_row_t res_pick;

  // Panel size and expansion sources differ per panel size
  assign is_800 = regs_in.size_ctl[`LFSRS_SIZE_LSB +: 2] == `LFSRS_SIZE_800;
  assign exp_640 = regs_in.expand_center[`LFSRS_EXPAND_BIT];
  assign exp_800 = graphics_mode_in ? regs_in.second_expand[`LFSRS_GFX_EXP_BIT] :
                   regs_in.second_expand[`LFSRS_TXT_EXP_BIT];
  assign center = regs_in.expand_center[`LFSRS_CENTER_BIT];
  assign row_one_full = {regs_in.overflow[`LFSRS_OVF_ONE_LSB +: 2], regs_in.row_one};

  // Resolution picks one of the four rows when centering without expansion
  always_comb begin
    case (misc_res_in)
      `LFSRS_RES_480: res_pick = row_one_full;
      `LFSRS_RES_350: res_pick = {regs_in.overflow[`LFSRS_OVF_TWO_LSB +: 2],
                                  regs_in.row_two};
      `LFSRS_RES_400: res_pick = {regs_in.overflow[`LFSRS_OVF_THREE_LSB +: 2],
                                  regs_in.row_three};
      default: res_pick = {regs_in.overflow[`LFSRS_OVF_FOUR_LSB +: 2],
                           regs_in.row_four};
    endcase
  end

  // Undefined combinations select nothing, so no pulse is produced
  always_comb begin
    pos_out = res_pick;
    valid_out = 1'b0;
    if (is_800 && exp_800) begin
      valid_out = 1'b1;
      if (misc_res_in == `LFSRS_RES_350) begin
        pos_out = {regs_in.exp_ovf[`LFSRS_EXP_OVF_LSB +: 2], regs_in.exp_row};
      end else begin
        pos_out = row_one_full;
      end
    end else if (!is_800 && exp_640) begin
      pos_out = row_one_full;
      valid_out = 1'b1;
    end else if (center && !(is_800 ? exp_800 : exp_640)) begin
      valid_out = 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: hdl/lfsrs_frame_start.sv
// Panel frame-start row select: register port, row choice, pulse shaper
// Functional notes
// - Panel row registers respond only while the unlock bit is set.
// - Each row is eight low bits plus two overflow bits, ten total.
// - The chosen row counts scanlines after the CRT frame start.
// - Small panel, no expansion, centering, resolution 11 uses row one.
// - Small panel with expansion on uses row one for every resolution.
// - Large panel with expansion uses row one unless resolution is 10.
// - Large panel expanded 350-line mode uses the separate expanded row pair.
// - No expansion, centering, resolution 10 uses row two for either panel.
// - Resolution 01 picks row three, 00 picks row four when centering.
// - Panel-size field value 01 means the large panel.
// - Large panel expansion follows graphics or text expansion bit by mode.
// - Every row register bit is read/write and clears at reset.
// - Output is one line wide, or two lines wide when selected.
`timescale 1ns/1ns
`default_nettype none
`include "lfsrs_cfg.svh"
module lfsrs_frame_start (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire lfsrs_pkg::lfsrs_io_req_t io_req_in,
  output logic [7:0] io_rdata_out,
  input wire logic [1:0] misc_res_in,
  input wire logic graphics_mode_in,
  input wire lfsrs_pkg::lfsrs_timing_t timing_in,
  output logic panel_frame_start_pulse_out
);
  import lfsrs_pkg::*;

  logic [3:0] slot;
  logic mapped;
  logic panel_reg;
  logic unlock;
  logic hit;
  logic [`LFSRS_NUM_SLOTS*8-1:0] flat_regs;
  lfsrs_regs_t regs;
  lfsrs_row_t sel_pos;
  logic sel_valid;
  logic two_line;
  lfsrs_row_t nxt_line;
  lfsrs_row_t line_ff;
  logic line_edge;
  logic trigger;
  lfsrs_state_t nxt_state;
  lfsrs_state_t state_ff;
  logic nxt_pulse;
  logic pulse_ff;

  // Index decode; only the two expansion controls sit outside the lock
  always_comb begin
    slot = `LFSRS_SLOT_ROW_ONE;
    mapped = 1'b1;
    panel_reg = 1'b1;
    if (io_req_in.index == `LFSRS_IDX_ROW_ONE) begin
      slot = `LFSRS_SLOT_ROW_ONE;
    end else if (io_req_in.index == `LFSRS_IDX_ROW_TWO) begin
      slot = `LFSRS_SLOT_ROW_TWO;
    end else if (io_req_in.index == `LFSRS_IDX_ROW_THREE) begin
      slot = `LFSRS_SLOT_ROW_THREE;
    end else if (io_req_in.index == `LFSRS_IDX_ROW_FOUR) begin
      slot = `LFSRS_SLOT_ROW_FOUR;
    end else if (io_req_in.index == `LFSRS_IDX_OVERFLOW) begin
      slot = `LFSRS_SLOT_OVERFLOW;
    end else if (io_req_in.index == `LFSRS_IDX_SIGNAL_CTL) begin
      slot = `LFSRS_SLOT_SIGNAL_CTL;
    end else if (io_req_in.index == `LFSRS_IDX_SIZE_CTL) begin
      slot = `LFSRS_SLOT_SIZE_CTL;
    end else if (io_req_in.index == `LFSRS_IDX_EXP_ROW) begin
      slot = `LFSRS_SLOT_EXP_ROW;
    end else if (io_req_in.index == `LFSRS_IDX_EXP_OVF) begin
      slot = `LFSRS_SLOT_EXP_OVF;
    end else if (io_req_in.index == `LFSRS_IDX_EXPAND_CENTER) begin
      slot = `LFSRS_SLOT_EXPAND_CENTER;
      panel_reg = 1'b0;
    end else if (io_req_in.index == `LFSRS_IDX_SECOND_EXPAND) begin
      slot = `LFSRS_SLOT_SECOND_EXPAND;
      panel_reg = 1'b0;
    end else begin
      mapped = 1'b0;
      panel_reg = 1'b0;
    end
  end

  // Locked panel registers read as zero and drop writes
  assign unlock = regs.expand_center[`LFSRS_UNLOCK_BIT];
  assign hit = mapped && (!panel_reg || unlock);

  // Storage for every byte register, reset to zero
  lfsrs_regfile u_regfile (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(io_req_in.wr && hit),
    .wr_slot_in(slot),
    .wdata_in(io_req_in.wdata),
    .rd_en_in(io_req_in.rd),
    .rd_hit_in(hit),
    .rd_slot_in(slot),
    .rdata_out(io_rdata_out),
    .all_regs_out(flat_regs)
  );

  // Unpack slots into named fields
  always_comb begin
    regs.row_one = flat_regs[`LFSRS_SLOT_ROW_ONE*8 +: 8];
    regs.row_two = flat_regs[`LFSRS_SLOT_ROW_TWO*8 +: 8];
    regs.row_three = flat_regs[`LFSRS_SLOT_ROW_THREE*8 +: 8];
    regs.row_four = flat_regs[`LFSRS_SLOT_ROW_FOUR*8 +: 8];
    regs.overflow = flat_regs[`LFSRS_SLOT_OVERFLOW*8 +: 8];
    regs.exp_row = flat_regs[`LFSRS_SLOT_EXP_ROW*8 +: 8];
    regs.exp_ovf = flat_regs[`LFSRS_SLOT_EXP_OVF*8 +: 8];
    regs.expand_center = flat_regs[`LFSRS_SLOT_EXPAND_CENTER*8 +: 8];
    regs.second_expand = flat_regs[`LFSRS_SLOT_SECOND_EXPAND*8 +: 8];
    regs.size_ctl = flat_regs[`LFSRS_SLOT_SIZE_CTL*8 +: 8];
  end

  assign two_line = flat_regs[`LFSRS_SLOT_SIGNAL_CTL*8 + `LFSRS_TWO_LINE_BIT];

  // Row choice from panel size, expansion, centering and resolution
  lfsrs_row_select u_select (
    .regs_in(regs),
    .misc_res_in(misc_res_in),
    .graphics_mode_in(graphics_mode_in),
    .pos_out(sel_pos),
    .valid_out(sel_valid)
  );

  // Scanline count; CRT frame start is line zero
  always_comb begin
    nxt_line = line_ff;
    if (timing_in.frame_start) begin
      nxt_line = 10'h000;
    end else if (timing_in.line_start) begin
      nxt_line = line_ff + 10'h001;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      line_ff <= 10'h000;
    end else begin
      line_ff <= nxt_line;
    end
  end

  // Compare against the new line so the pulse aligns with its start
  assign line_edge = timing_in.frame_start || timing_in.line_start;
  assign trigger = line_edge && sel_valid && (nxt_line == sel_pos);

  // Shaper holds the output for one or two whole lines
  always_comb begin
    nxt_state = state_ff;
    nxt_pulse = pulse_ff;
    case (state_ff)
      LFSRS_IDLE: begin
        if (trigger) begin
          nxt_state = LFSRS_LINE_A;
          nxt_pulse = 1'b1;
        end
      end
      LFSRS_LINE_A: begin
        if (trigger) begin
          nxt_state = LFSRS_LINE_A;
        end else if (timing_in.frame_start) begin
          nxt_state = LFSRS_IDLE;
          nxt_pulse = 1'b0;
        end else if (timing_in.line_start) begin
          if (two_line) begin
            nxt_state = LFSRS_LINE_B;
          end else begin
            nxt_state = LFSRS_IDLE;
            nxt_pulse = 1'b0;
          end
        end
      end
      LFSRS_LINE_B: begin
        if (trigger) begin
          nxt_state = LFSRS_LINE_A;
        end else if (line_edge) begin
          nxt_state = LFSRS_IDLE;
          nxt_pulse = 1'b0;
        end
      end
      default: begin
        nxt_state = LFSRS_IDLE;
        nxt_pulse = 1'b0;
      end
    endcase
  end

  // A frame start mid-pulse restarts cleanly rather than stretching it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= LFSRS_IDLE;
      pulse_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pulse_ff <= nxt_pulse;
    end
  end

  assign panel_frame_start_pulse_out = pulse_ff;

  // Checks on register access, row choice and pulse shape
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  logic p_is_800;
  logic p_exp_800;
  assign p_is_800 = regs.size_ctl[`LFSRS_SIZE_LSB +: 2] == `LFSRS_SIZE_800;
  assign p_exp_800 = graphics_mode_in ? regs.second_expand[`LFSRS_GFX_EXP_BIT] :
                     regs.second_expand[`LFSRS_TXT_EXP_BIT];

  locked_write_a: assert property (
    io_req_in.wr && io_req_in.index == `LFSRS_IDX_ROW_ONE && !unlock
    |=> $stable(regs.row_one))
    else $error("row one changed while locked");

  row_write_a: assert property (
    io_req_in.wr && io_req_in.index == `LFSRS_IDX_ROW_TWO && unlock ##1 !io_req_in.wr
    ##1 io_req_in.rd && io_req_in.index == `LFSRS_IDX_ROW_TWO && unlock && !io_req_in.wr
    |=> io_rdata_out == $past(io_req_in.wdata, 3))
    else $error("row two read back differs from write");

  locked_read_a: assert property (
    io_req_in.rd && panel_reg && !unlock |=> io_rdata_out == 8'h00)
    else $error("locked register read not zero");

  res480_a: assert property (
    !p_is_800 && !regs.expand_center[`LFSRS_EXPAND_BIT] &&
    regs.expand_center[`LFSRS_CENTER_BIT] && misc_res_in == `LFSRS_RES_480
    |-> sel_valid && sel_pos == {regs.overflow[7:6], regs.row_one})
    else $error("480-line row choice wrong");

  exp640_a: assert property (
    !p_is_800 && regs.expand_center[`LFSRS_EXPAND_BIT]
    |-> sel_valid && sel_pos == {regs.overflow[7:6], regs.row_one})
    else $error("expanded small panel row wrong");

  exp800_a: assert property (
    p_is_800 && p_exp_800 && misc_res_in != `LFSRS_RES_350
    |-> sel_valid && sel_pos == {regs.overflow[7:6], regs.row_one})
    else $error("expanded large panel row wrong");

  exp350_a: assert property (
    p_is_800 && p_exp_800 && misc_res_in == `LFSRS_RES_350
    |-> sel_pos == {regs.exp_ovf[1:0], regs.exp_row})
    else $error("expanded 350-line row wrong");

  res350_a: assert property (
    !(p_is_800 ? p_exp_800 : regs.expand_center[`LFSRS_EXPAND_BIT]) &&
    regs.expand_center[`LFSRS_CENTER_BIT] && misc_res_in == `LFSRS_RES_350
    |-> sel_pos == {regs.overflow[5:4], regs.row_two})
    else $error("350-line row wrong");

  res400_a: assert property (
    !(p_is_800 ? p_exp_800 : regs.expand_center[`LFSRS_EXPAND_BIT]) &&
    regs.expand_center[`LFSRS_CENTER_BIT] && misc_res_in == `LFSRS_RES_400
    |-> sel_pos == {regs.overflow[3:2], regs.row_three})
    else $error("400-line row wrong");

  pulse_start_a: assert property (
    line_edge && sel_valid && nxt_line == sel_pos
    |=> panel_frame_start_pulse_out && state_ff == LFSRS_LINE_A)
    else $error("pulse missed its row");

  one_line_a: assert property (
    state_ff == LFSRS_LINE_A && timing_in.line_start && !two_line && !trigger
    |=> !panel_frame_start_pulse_out)
    else $error("one-line pulse too long");

  two_line_a: assert property (
    state_ff == LFSRS_LINE_A && timing_in.line_start && two_line &&
    !timing_in.frame_start && !trigger
    |=> panel_frame_start_pulse_out && state_ff == LFSRS_LINE_B)
    else $error("two-line pulse ended early");

  no_sel_a: assert property (
    !sel_valid && state_ff == LFSRS_IDLE |=> !panel_frame_start_pulse_out)
    else $error("pulse without a selected row");

  one_line_c: cover property (
    trigger && !two_line ##1 panel_frame_start_pulse_out [*3]);
  two_line_c: cover property (state_ff == LFSRS_LINE_B);
  exp350_c: cover property (p_is_800 && p_exp_800 && misc_res_in == `LFSRS_RES_350 && trigger);
  unlock_c: cover property (io_req_in.wr && hit && panel_reg);
endmodule
`default_nettype wire

// file: test/lfsrs_panel_model.sv
// Panel-side model that times the frame-start pulse in scanlines
`timescale 1ns/1ns
`default_nettype none
module lfsrs_panel_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire lfsrs_pkg::lfsrs_timing_t timing_in,
  input wire logic pulse_in,
  output logic [9:0] rise_line_out,
  output logic [3:0] width_out,
  output logic [3:0] rises_out
);
  import lfsrs_pkg::*;
  logic [9:0] line_ff;
  logic pulse_ff;

  // Line count restarts at CRT frame start; a rise is stamped with it
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      line_ff <= 10'h000;
      pulse_ff <= 1'b0;
      rise_line_out <= 10'h000;
      width_out <= 4'h0;
      rises_out <= 4'h0;
    end else begin
      pulse_ff <= pulse_in;
      if (timing_in.frame_start) begin
        line_ff <= 10'h000;
        rises_out <= 4'h0;
        width_out <= 4'h0;
      end else if (timing_in.line_start) begin
        line_ff <= line_ff + 10'h001;
      end
      // Width counted in line boundaries crossed while high
      if (pulse_in && !pulse_ff) begin
        rise_line_out <= line_ff;
        rises_out <= rises_out + 4'h1;
        width_out <= 4'h0;
      end else if (pulse_in && (timing_in.frame_start || timing_in.line_start)) begin
        width_out <= width_out + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: test/tb_lcd_frame_start_row_select.sv
// Self-checking bench for the panel frame-start row select block
`timescale 1ns/1ns
`default_nettype none
`include "lfsrs_cfg.svh"
module tb_lcd_frame_start_row_select;
  import lfsrs_pkg::*;
  typedef struct packed {
    logic [7:0] size;
    logic [7:0] ctl;
    logic [7:0] sec;
    logic gfx;
    logic [1:0] res;
    logic hit;
    logic [9:0] row;
  } lfsrs_tb_case_t;
  logic clk_in;
  logic rst_b_in;
  lfsrs_io_req_t req;
  lfsrs_timing_t tm;
  logic [1:0] res;
  logic gfx;
  logic [7:0] rdata;
  logic pulse;
  logic [9:0] rise_line;
  logic [3:0] width;
  logic [3:0] rises;
  int err_total;
  int cmp_count;
  lfsrs_tb_case_t cases [14];

  lfsrs_frame_start uut (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .io_req_in(req),
    .io_rdata_out(rdata),
    .misc_res_in(res),
    .graphics_mode_in(gfx),
    .timing_in(tm),
    .panel_frame_start_pulse_out(pulse)
  );

  lfsrs_panel_model panel (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .timing_in(tm),
    .pulse_in(pulse),
    .rise_line_out(rise_line),
    .width_out(width),
    .rises_out(rises)
  );

  // 25 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Register write; request held for exactly one taken edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, index: idx, wdata: d};
    @(posedge clk_in);
    req <= '0;
  endtask

  // Read data lands at the taken edge and is checked just after it
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 8'h00};
    @(posedge clk_in);
    req <= '0;
    #1 check({2'h0, rdata}, {2'h0, exp});
  endtask

  // One CRT frame, three clocks per scanline
  task automatic run_frame(input int lines);
    @(posedge clk_in);
    tm <= '{frame_start: 1'b1, line_start: 1'b0};
    @(posedge clk_in);
    tm <= '0;
    for (int i = 1; i < lines; i++) begin
      repeat (2) @(posedge clk_in);
      tm <= '{frame_start: 1'b0, line_start: 1'b1};
      @(posedge clk_in);
      tm <= '0;
    end
    repeat (3) @(posedge clk_in);
  endtask

  task automatic frame_chk(input int lines, input logic hit, input logic [9:0] row,
                           input logic [3:0] w);
    run_frame(lines);
    check({6'h00, rises}, hit ? 10'h001 : 10'h000);
    if (hit) begin
      check(rise_line, row);
      check({6'h00, width}, {6'h00, w});
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rst_b_in = 1'b0;
    req = '0;
    tm = '0;
    res = 2'h0;
    gfx = 1'h0;
    err_total = 0;
    cmp_count = 0;
    // size ctl, expand/centre, second expand, gfx, resolution, hit, row
    cases = '{
      '{8'h00, 8'h81, 8'h00, 1'h1, 2'h3, 1'h1, 10'h003},
      '{8'h00, 8'h82, 8'h00, 1'h1, 2'h0, 1'h1, 10'h003},
      '{8'h00, 8'h82, 8'h00, 1'h0, 2'h2, 1'h1, 10'h003},
      '{8'h04, 8'h81, 8'h02, 1'h1, 2'h0, 1'h1, 10'h003},
      '{8'h04, 8'h80, 8'h01, 1'h0, 2'h3, 1'h1, 10'h003},
      '{8'h04, 8'h80, 8'h02, 1'h1, 2'h2, 1'h1, 10'h00b},
      '{8'h04, 8'h81, 8'h01, 1'h0, 2'h2, 1'h1, 10'h00b},
      '{8'h04, 8'h81, 8'h02, 1'h0, 2'h2, 1'h1, 10'h005},
      '{8'h00, 8'h81, 8'h00, 1'h1, 2'h2, 1'h1, 10'h005},
      '{8'h04, 8'h81, 8'h00, 1'h1, 2'h2, 1'h1, 10'h005},
      '{8'h04, 8'h81, 8'h00, 1'h1, 2'h1, 1'h1, 10'h007},
      '{8'h04, 8'h81, 8'h00, 1'h0, 2'h0, 1'h1, 10'h009},
      '{8'h00, 8'h80, 8'h00, 1'h1, 2'h3, 1'h0, 10'h000},
      '{8'h08, 8'h82, 8'h00, 1'h1, 2'h2, 1'h1, 10'h003}
    };
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    // Start-up programming: unlock first, then distinct rows
    wr(`LFSRS_IDX_EXPAND_CENTER, 8'h80);
    wr(`LFSRS_IDX_ROW_ONE, 8'h03);
    wr(`LFSRS_IDX_ROW_TWO, 8'h05);
    wr(`LFSRS_IDX_ROW_THREE, 8'h07);
    wr(`LFSRS_IDX_ROW_FOUR, 8'h09);
    wr(`LFSRS_IDX_EXP_ROW, 8'h0b);
    // Selection table, one frame per row
    for (int i = 0; i < 14; i++) begin
      wr(`LFSRS_IDX_SIZE_CTL, cases[i].size);
      wr(`LFSRS_IDX_EXPAND_CENTER, cases[i].ctl);
      wr(`LFSRS_IDX_SECOND_EXPAND, cases[i].sec);
      res <= cases[i].res;
      gfx <= cases[i].gfx;
      frame_chk(16, cases[i].hit, cases[i].row, 4'h1);
      $display("table case %0d done", i);
    end
    // Locked port drops writes and reads back zero
    wr(`LFSRS_IDX_EXPAND_CENTER, 8'h01);
    wr(`LFSRS_IDX_ROW_ONE, 8'h77);
    rdchk(`LFSRS_IDX_ROW_ONE, 8'h00);
    wr(`LFSRS_IDX_EXPAND_CENTER, 8'h81);
    rdchk(`LFSRS_IDX_ROW_ONE, 8'h03);
    rdchk(8'h40, 8'h00);
    $display("lock test done");
    // Complementary bytes a5 and 5a in rows one and two, then ff and 3c, each read back
    wr(`LFSRS_IDX_ROW_ONE, 8'ha5);
    wr(`LFSRS_IDX_ROW_TWO, 8'h5a);
    rdchk(`LFSRS_IDX_ROW_ONE, 8'ha5);
    rdchk(`LFSRS_IDX_ROW_TWO, 8'h5a);
    wr(`LFSRS_IDX_ROW_ONE, 8'hff);
    rdchk(`LFSRS_IDX_ROW_ONE, 8'hff);
    wr(`LFSRS_IDX_ROW_TWO, 8'h3c);
    rdchk(`LFSRS_IDX_ROW_TWO, 8'h3c);
    $display("read write test done");
    // Ten-bit row from overflow; neighbour overflow bits must not leak
    wr(`LFSRS_IDX_SIZE_CTL, 8'h00);
    wr(`LFSRS_IDX_OVERFLOW, 8'h4c);
    wr(`LFSRS_IDX_ROW_ONE, 8'h02);
    rdchk(`LFSRS_IDX_OVERFLOW, 8'h4c);
    res <= 2'h3;
    frame_chk(262, 1'h1, 10'h102, 4'h1);
    wr(`LFSRS_IDX_SIGNAL_CTL, 8'h08);
    frame_chk(262, 1'h1, 10'h102, 4'h2);
    $display("overflow and width test done");
    // Expanded 350-line row takes its own overflow, not the shared one
    wr(`LFSRS_IDX_EXP_OVF, 8'h01);
    wr(`LFSRS_IDX_SIZE_CTL, 8'h04);
    wr(`LFSRS_IDX_SECOND_EXPAND, 8'h02);
    res <= 2'h2;
    gfx <= 1'h1;
    frame_chk(270, 1'h1, 10'h10b, 4'h2);
    $display("expanded overflow test done");
    // Reset in mid-run clears every register
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    check({9'h000, pulse}, 10'h000);
    wr(`LFSRS_IDX_EXPAND_CENTER, 8'h80);
    rdchk(`LFSRS_IDX_ROW_ONE, 8'h00);
    rdchk(`LFSRS_IDX_ROW_TWO, 8'h00);
    rdchk(`LFSRS_IDX_OVERFLOW, 8'h00);
    frame_chk(8, 1'h0, 10'h000, 4'h0);
    $display("reset test done");
    results();
  end
endmodule
`default_nettype wire
